// >>> src/test_signal_mux_and_selftest.sv
/*
  Test support logic: digital self-test writing a signature into the FIFO,
  test bus routing onto the data pins, auxiliary pin selectors and
  pseudo-random sequence generation with framing.
  Assumes all inputs are synchronous to ref_clk_in, the FIFO accepts one
  write per cycle, and bit_tick_in marks each transmit bit period.
*/
`timescale 1ns/1ns
module test_signal_mux_and_selftest
  import test_support_pkg::*;
#(
  parameter logic [3:0] PREAMBLE_BITS = 4'h8,
  parameter logic [7:0] SYNC_BYTE     = 8'hA5
) (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // Self-test control
  input  wire logic [7:0] auto_test_control_in,
  input  wire logic       crc_calc_command_in,
  // Test select fields
  input  wire logic [4:0] test_bus_group_select_in,
  input  wire logic [2:0] test_bus_bit_select_in,
  input  wire logic [1:0] prbs_mode_in,
  input  wire logic       framing_mode_in,
  // Aux selectors and DAC values
  input  wire logic [7:0] aux_output_select_in,
  input  wire logic [5:0] dac_value_first_in,
  input  wire logic [5:0] dac_value_second_in,
  // Receiver and oscillator probes
  input  wire logic       rx_serial_data_in,
  input  wire logic       bit_collision_in,
  input  wire logic       rx_valid_strobe_in,
  input  wire logic       rx_stop_detected_in,
  input  wire logic       receiver_held_reset_in,
  input  wire logic       osc_clock_stable_in,
  input  wire logic       osc_clock_raw_in,
  input  wire logic       subcarrier_detected_in,
  input  wire logic [5:0] correlation_level_in,
  input  wire logic [5:0] minimum_rx_level_in,
  input  wire logic [5:0] adc_in_phase_in,
  input  wire logic [5:0] adc_quadrature_in,
  // Frame phase indicators
  input  wire logic       baud_106_in,
  input  wire logic       tx_start_bit_in,
  input  wire logic       tx_data_bit_in,
  input  wire logic       tx_parity_bit_in,
  input  wire logic       tx_crc_bit_in,
  input  wire logic       rx_start_bit_in,
  input  wire logic       rx_data_bit_in,
  input  wire logic       rx_parity_bit_in,
  input  wire logic       rx_crc_bit_in,
  // Transmit command
  input  wire logic       transmit_command_in,
  input  wire logic       transmit_stop_in,
  input  wire logic       bit_tick_in,
  // FIFO and CRC side
  output logic            fifo_flush_out,
  output logic            fifo_write_out,
  output logic [7:0]      fifo_write_data_out,
  output logic            crc_start_out,
  output logic            selftest_busy_out,
  output logic            selftest_done_out,
  // Data pins D6..D1 at [5:0]
  output logic [5:0]      data_pins_out,
  // Aux pins
  output logic            aux_pin_first_out,
  output logic            aux_pin_first_oe_out,
  output logic            aux_first_dac_en_out,
  output logic [5:0]      aux_first_dac_out,
  output logic            aux_pin_second_out,
  output logic            aux_pin_second_oe_out,
  output logic            aux_second_dac_en_out,
  output logic [5:0]      aux_second_dac_out,
  // Pseudo-random transmit lane
  output logic            prbs_bit_out,
  output logic            prbs_active_out
);

  // Returns {dac_en, oe, level}
  function automatic logic [2:0] aux_drive(input logic [3:0] sel, input logic txa, input logic rxa,
                                           input logic sub, input logic tbb);
    logic [2:0] r;
    r = 3'h0;
    case (sel)
      AUX_DAC_OWN, AUX_DAC_CORR, AUX_DAC_MIN, AUX_DAC_ADCI, AUX_DAC_ADCQ: r = 3'h4;
      AUX_HIGH:    r = 3'h3;
      AUX_LOW:     r = 3'h2;
      AUX_TX_ACT:  r = {2'h1, txa};
      AUX_RX_ACT:  r = {2'h1, rxa};
      AUX_SUBCARR: r = {2'h1, sub};
      AUX_BUS_BIT: r = {2'h1, tbb};
      default:     r = 3'h0;
    endcase
    return r;
  endfunction

  function automatic logic [5:0] aux_dac(input logic [3:0] sel, input logic [5:0] own);
    logic [5:0] v;
    v = 6'h00;
    case (sel)
      AUX_DAC_OWN:  v = own;
      AUX_DAC_CORR: v = correlation_level_in;
      AUX_DAC_MIN:  v = minimum_rx_level_in;
      AUX_DAC_ADCI: v = adc_in_phase_in;
      AUX_DAC_ADCQ: v = adc_quadrature_in;
      default:      v = 6'h00;
    endcase
    return v;
  endfunction

  function automatic logic [15:0] prbs_step(input logic [14:0] s, input logic [1:0] mode);
    logic fb;
    fb = (mode == PRBS_15) ? (s[14] ^ s[13]) : (s[8] ^ s[4]);
    return {s[13:0], fb, fb};
  endfunction

  // Oscillator divider and test bus
  logic       osc_prev_reg, osc_prev_next;
  logic [1:0] osc_cnt_reg, osc_cnt_next;
  logic       osc_div8_reg, osc_div8_next;
  logic [5:0] pins_reg, pins_next;
  logic [7:0] tb_vec;
  logic       tb_bit;

  always_comb begin
    osc_prev_next = osc_clock_raw_in;
    osc_cnt_next  = osc_cnt_reg;
    osc_div8_next = osc_div8_reg;
    if (osc_clock_raw_in && !osc_prev_reg) begin
      osc_cnt_next = osc_cnt_reg + 2'h1;
      if (osc_cnt_reg == OSC_HALF_LAST) begin
        osc_div8_next = !osc_div8_reg;
      end
    end
    tb_vec = 8'h00;
    if (test_bus_group_select_in == TB_GROUP_RX) begin
      tb_vec[6] = rx_serial_data_in;
      tb_vec[5] = bit_collision_in && baud_106_in;
      tb_vec[4] = rx_valid_strobe_in;
      tb_vec[3] = rx_stop_detected_in;
      tb_vec[2] = receiver_held_reset_in;
    end else if (test_bus_group_select_in == TB_GROUP_OSC) begin
      tb_vec[6] = osc_clock_stable_in;
      tb_vec[5] = osc_div8_reg;
      tb_vec[2] = osc_clock_raw_in;
    end
    pins_next = tb_vec[6:1];
    tb_bit    = tb_vec[test_bus_bit_select_in];
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      osc_prev_reg <= 1'b0;
      osc_cnt_reg  <= 2'h0;
      osc_div8_reg <= 1'b0;
      pins_reg     <= 6'h00;
    end else begin
      osc_prev_reg <= osc_prev_next;
      osc_cnt_reg  <= osc_cnt_next;
      osc_div8_reg <= osc_div8_next;
      pins_reg     <= pins_next;
    end
  end
  assign data_pins_out = pins_reg;

  // Aux pins
  logic       tx_active, rx_active;
  logic [2:0] aux_pin_first_drv, aux_pin_second_drv;
  logic [8:0] aux_pin_first_reg, aux_pin_first_next, aux_pin_second_reg, aux_pin_second_next;

  always_comb begin
    tx_active = baud_106_in ? (tx_start_bit_in || tx_data_bit_in || tx_parity_bit_in || tx_crc_bit_in)
                            : (tx_data_bit_in || tx_crc_bit_in);
    rx_active = baud_106_in ? (rx_data_bit_in || rx_parity_bit_in || rx_crc_bit_in)
                            : (rx_data_bit_in || rx_crc_bit_in);
    aux_pin_first_drv  = aux_drive(aux_output_select_in[7:4], tx_active, rx_active, subcarrier_detected_in, tb_bit);
    aux_pin_second_drv  = aux_drive(aux_output_select_in[3:0], tx_active, rx_active, subcarrier_detected_in, tb_bit);
    aux_pin_first_next = {aux_pin_first_drv, aux_dac(aux_output_select_in[7:4], dac_value_first_in)};
    aux_pin_second_next = {aux_pin_second_drv, aux_dac(aux_output_select_in[3:0], dac_value_second_in)};
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aux_pin_first_reg <= 9'h000;
      aux_pin_second_reg <= 9'h000;
    end else begin
      aux_pin_first_reg <= aux_pin_first_next;
      aux_pin_second_reg <= aux_pin_second_next;
    end
  end
  assign aux_first_dac_en_out  = aux_pin_first_reg[8];
  assign aux_pin_first_oe_out  = aux_pin_first_reg[7];
  assign aux_pin_first_out     = aux_pin_first_reg[6];
  assign aux_first_dac_out     = aux_pin_first_reg[5:0];
  assign aux_second_dac_en_out = aux_pin_second_reg[8];
  assign aux_pin_second_oe_out = aux_pin_second_reg[7];
  assign aux_pin_second_out    = aux_pin_second_reg[6];
  assign aux_second_dac_out    = aux_pin_second_reg[5:0];

  // Self-test sequencer
  selftest_state_e st_reg, st_next;
  logic [5:0]      idx_reg, idx_next;
  logic            flush_reg, flush_next, wr_reg, wr_next, done_reg, done_next, crc_reg, crc_next;
  logic [7:0]      wdata_reg, wdata_next;
  logic            busy_reg, busy_next;
  logic            armed;

  always_comb begin
    armed      = (auto_test_control_in == SELFTEST_ARM_CODE);
    st_next    = st_reg;
    idx_next   = idx_reg;
    flush_next = 1'b0;
    wr_next    = 1'b0;
    done_next  = 1'b0;
    crc_next   = 1'b0;
    wdata_next = wdata_reg;
    case (st_reg)
      ST_IDLE: begin
        if (crc_calc_command_in && armed) begin
          st_next    = ST_FLUSH;
          flush_next = 1'b1;
        end else if (crc_calc_command_in) begin
          crc_next = 1'b1;
        end
      end
      ST_FLUSH: begin
        st_next    = ST_WRITE;
        idx_next   = 6'h00;
        wr_next    = 1'b1;
        wdata_next = SIG_ROM[0];
      end
      ST_WRITE: begin
        if ({1'b0, idx_reg} == SIG_LAST - 7'h01) begin
          st_next = ST_DONE;
        end
        idx_next   = idx_reg + 6'h01;
        wr_next    = 1'b1;
        wdata_next = SIG_ROM[idx_reg + 6'h01];
      end
      default: begin
        st_next   = ST_IDLE;
        done_next = 1'b1;
      end
    endcase
    busy_next = (st_next != ST_IDLE) || done_next;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg    <= ST_IDLE;
      idx_reg   <= 6'h00;
      flush_reg <= 1'b0;
      wr_reg    <= 1'b0;
      done_reg  <= 1'b0;
      crc_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      wdata_reg <= 8'h00;
    end else begin
      st_reg    <= st_next;
      idx_reg   <= idx_next;
      flush_reg <= flush_next;
      wr_reg    <= wr_next;
      done_reg  <= done_next;
      crc_reg   <= crc_next;
      busy_reg  <= busy_next;
      wdata_reg <= wdata_next;
    end
  end
  assign fifo_flush_out      = flush_reg;
  assign fifo_write_out      = wr_reg;
  assign fifo_write_data_out = wdata_reg;
  assign crc_start_out       = crc_reg;
  assign selftest_done_out   = done_reg;
  assign selftest_busy_out   = busy_reg;

  // Pseudo-random sequence with framing
  prbs_state_e pr_reg, pr_next;
  logic [14:0] lfsr_reg, lfsr_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        par_reg, par_next, pbit_reg, pbit_next, pact_reg, pact_next;
  logic [1:0]  pmode_reg, pmode_next;
  logic [15:0] step;

  always_comb begin
    pr_next    = pr_reg;
    lfsr_next  = lfsr_reg;
    cnt_next   = cnt_reg;
    par_next   = par_reg;
    pbit_next  = pbit_reg;
    pmode_next = pmode_reg;
    step       = prbs_step(lfsr_reg, pmode_reg);
    if (pr_reg == PR_IDLE) begin
      if (transmit_command_in && prbs_mode_in != PRBS_OFF) begin
        pmode_next = prbs_mode_in;
        lfsr_next  = PRBS_SEED;
        cnt_next   = 4'h0;
        pr_next    = (framing_mode_in == FRAME_HIGH) ? PR_PREAMB : PR_START;
      end
    end else if (transmit_stop_in || prbs_mode_in == PRBS_OFF) begin
      pr_next   = PR_IDLE;
      pbit_next = 1'b0;
    end else if (bit_tick_in) begin
      case (pr_reg)
        PR_PREAMB: begin
          pbit_next = 1'b0;
          cnt_next  = cnt_reg + 4'h1;
          if (cnt_reg == PREAMBLE_BITS - 4'h1) begin
            pr_next  = PR_SYNC;
            cnt_next = 4'h0;
          end
        end
        PR_SYNC: begin
          pbit_next = SYNC_BYTE[cnt_reg[2:0]];
          cnt_next  = cnt_reg + 4'h1;
          if (cnt_reg == BYTE_LAST) begin
            pr_next  = PR_START;
            cnt_next = 4'h0;
          end
        end
        PR_START: begin
          pbit_next = 1'b1;
          par_next  = 1'b1;
          pr_next   = PR_DATA;
        end
        PR_DATA: begin
          pbit_next = step[0];
          lfsr_next = step[15:1];
          par_next  = par_reg ^ step[0];
          cnt_next  = cnt_reg + 4'h1;
          if (cnt_reg == BYTE_LAST) begin
            pr_next  = PR_PARITY;
            cnt_next = 4'h0;
          end
        end
        default: begin
          pbit_next = par_reg;
          par_next  = 1'b1;
          pr_next   = PR_DATA;
        end
      endcase
    end
    pact_next = (pr_next != PR_IDLE);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pr_reg    <= PR_IDLE;
      lfsr_reg  <= PRBS_SEED;
      cnt_reg   <= 4'h0;
      par_reg   <= 1'b1;
      pbit_reg  <= 1'b0;
      pact_reg  <= 1'b0;
      pmode_reg <= PRBS_OFF;
    end else begin
      pr_reg    <= pr_next;
      lfsr_reg  <= lfsr_next;
      cnt_reg   <= cnt_next;
      par_reg   <= par_next;
      pbit_reg  <= pbit_next;
      pact_reg  <= pact_next;
      pmode_reg <= pmode_next;
    end
  end
  assign prbs_bit_out    = pbit_reg;
  assign prbs_active_out = pact_reg;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  logic [6:0] wr_count_reg;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_count_reg <= 7'h00;
    end else if (fifo_flush_out) begin
      wr_count_reg <= 7'h00;
    end else if (fifo_write_out) begin
      wr_count_reg <= wr_count_reg + 7'h01;
    end
  end

  AST_LAUNCH_SELFTEST: assert property ((st_reg == ST_IDLE) && crc_calc_command_in && armed
    |=> fifo_flush_out && !crc_start_out ##1 fifo_write_out && fifo_write_data_out == 8'h00)
    else $error("armed CRC command did not start self-test");
  AST_PLAIN_CRC: assert property ((st_reg == ST_IDLE) && crc_calc_command_in && !armed
    |=> crc_start_out && !fifo_flush_out)
    else $error("unarmed CRC command did not start CRC");
  AST_SIG_COUNT: assert property (selftest_done_out |-> wr_count_reg == 7'h40)
    else $error("self-test did not write 64 bytes");
  AST_SIG_BURST: assert property (fifo_flush_out |=> fifo_write_out [*8])
    else $error("signature writes not back to back");
  AST_GROUP_RX: assert property (test_bus_group_select_in == TB_GROUP_RX
    |=> data_pins_out[5] == $past(rx_serial_data_in) && data_pins_out[0] == 1'b0)
    else $error("receive group not on data pins");
  AST_GROUP_OSC: assert property (test_bus_group_select_in == TB_GROUP_OSC
    |=> data_pins_out[1] == $past(osc_clock_raw_in) && data_pins_out[3:2] == 2'h0)
    else $error("oscillator group wrong");
  AST_AUX_FLOAT: assert property (aux_output_select_in[7:4] == AUX_FLOAT |=> !aux_pin_first_oe_out)
    else $error("first aux pin driven when floating");
  AST_AUX_LOW: assert property (aux_output_select_in[3:0] == AUX_LOW
    |=> aux_pin_second_oe_out && !aux_pin_second_out)
    else $error("second aux pin not driven low");
  AST_DAC_OWN: assert property (aux_output_select_in[7:4] == AUX_DAC_OWN
    |=> aux_first_dac_en_out && aux_first_dac_out == $past(dac_value_first_in))
    else $error("first DAC does not follow its value");
  AST_TX_106: assert property (baud_106_in && tx_start_bit_in && aux_output_select_in[7:4] == AUX_TX_ACT
    |=> aux_pin_first_out)
    else $error("transmit-active missing on start bit");
  AST_RX_HIGH: assert property (!baud_106_in && !rx_data_bit_in && !rx_crc_bit_in
    && aux_output_select_in[3:0] == AUX_RX_ACT |=> !aux_pin_second_out)
    else $error("receive-active high outside data and CRC");
  AST_RESERVED: assert property (aux_output_select_in[7:4] == 4'h3
    |=> !aux_pin_first_oe_out && !aux_first_dac_en_out)
    else $error("reserved code drives first aux pin");
  AST_PRBS_START: assert property ((pr_reg == PR_IDLE) && transmit_command_in && prbs_mode_in != PRBS_OFF
    |=> prbs_active_out)
    else $error("sequence did not start");

  COV_SELFTEST: cover property (selftest_done_out);
  COV_BUS_BIT: cover property (aux_output_select_in == 8'hFF && test_bus_bit_select_in == 3'h6);
  COV_PRBS_PARITY: cover property (pr_reg == PR_PARITY && bit_tick_in);

endmodule

// >>> src/test_support_pkg.sv
/*
  Constants for the test support block: self-test arming and signature,
  test bus group codes, auxiliary selector codes, oscillator divider and
  pseudo-random sequence codes.
  Assumes one system clock and that the register bits arrive as plain levels.
*/
package test_support_pkg;

  localparam logic [7:0] SELFTEST_ARM_CODE = 8'h09;
  localparam int         SIG_BYTES         = 64;
  localparam logic [6:0] SIG_LAST          = 7'h3F;
  // Signature of the current silicon version
  localparam logic [7:0] SIG_ROM [0:63] = '{
    8'h00, 8'hEB, 8'h66, 8'hBA, 8'h57, 8'hBF, 8'h23, 8'h95, 8'hD0, 8'hE3, 8'h0D, 8'h3D, 8'h27, 8'h89, 8'h5C, 8'hDE,
    8'h9D, 8'h3B, 8'hA7, 8'h00, 8'h21, 8'h5B, 8'h89, 8'h82, 8'h51, 8'h3A, 8'hEB, 8'h02, 8'h0C, 8'hA5, 8'h00, 8'h49,
    8'h7C, 8'h84, 8'h4D, 8'hB3, 8'hCC, 8'hD2, 8'h1B, 8'h81, 8'h5D, 8'h48, 8'h76, 8'hD5, 8'h71, 8'h61, 8'h21, 8'hA9,
    8'h86, 8'h96, 8'h83, 8'h38, 8'hCF, 8'h9D, 8'h5B, 8'h6D, 8'hDC, 8'h15, 8'hBA, 8'h3E, 8'h7D, 8'h95, 8'h3B, 8'h2F
  };

  localparam logic [4:0] TB_GROUP_RX  = 5'h07;
  localparam logic [4:0] TB_GROUP_OSC = 5'h0D;

  localparam logic [3:0] AUX_FLOAT    = 4'h0;
  localparam logic [3:0] AUX_DAC_OWN  = 4'h1;
  localparam logic [3:0] AUX_DAC_CORR = 4'h2;
  localparam logic [3:0] AUX_DAC_MIN  = 4'h4;
  localparam logic [3:0] AUX_DAC_ADCI = 4'h5;
  localparam logic [3:0] AUX_DAC_ADCQ = 4'h6;
  localparam logic [3:0] AUX_HIGH     = 4'hA;
  localparam logic [3:0] AUX_LOW      = 4'hB;
  localparam logic [3:0] AUX_TX_ACT   = 4'hC;
  localparam logic [3:0] AUX_RX_ACT   = 4'hD;
  localparam logic [3:0] AUX_SUBCARR  = 4'hE;
  localparam logic [3:0] AUX_BUS_BIT  = 4'hF;

  localparam logic [1:0] OSC_HALF_LAST = 2'h3;

  localparam logic [1:0] PRBS_OFF = 2'h0;
  localparam logic [1:0] PRBS_9   = 2'h1;
  localparam logic [1:0] PRBS_15  = 2'h2;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;

  localparam logic       FRAME_106  = 1'h0;
  localparam logic       FRAME_HIGH = 1'h1;
  localparam logic [3:0] BYTE_LAST  = 4'h7;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FLUSH = 2'b01,
    ST_WRITE = 2'b10,
    ST_DONE  = 2'b11
  } selftest_state_e;

  typedef enum logic [2:0] {
    PR_IDLE   = 3'b000,
    PR_PREAMB = 3'b001,
    PR_SYNC   = 3'b010,
    PR_START  = 3'b011,
    PR_DATA   = 3'b100,
    PR_PARITY = 3'b101
  } prbs_state_e;

endpackage

// >>> tb/scope_probe.sv
/* Measurement side model: a free-running oscillator source and the aux pins
   seen through pull-down resistors. Assumes the aux pin ports of the test block. */
`timescale 1ns/1ns
module scope_probe (
  // Oscillator source
  output logic      osc_clock_raw_out,
  // Aux pins and their levels
  input  wire logic first_in,
  input  wire logic first_oe_in,
  input  wire logic second_in,
  input  wire logic second_oe_in,
  output logic      first_level_out,
  output logic      second_level_out
);
  // Edges never meet the bench's clock, drive or sample instants
  initial begin
    osc_clock_raw_out = 1'b0;
    #7;
    forever #40 osc_clock_raw_out = ~osc_clock_raw_out;
  end
  // A released pin falls to the pull-down level
  assign first_level_out  = first_oe_in ? first_in : 1'b0;
  assign second_level_out = second_oe_in ? second_in : 1'b0;
endmodule

// >>> tb/testbench.sv
/* Self-checking bench for the test support block: self-test, pin routing, aux selectors, PRBS.
   Assumes the test support package and the measurement side model. */
`timescale 1ns/1ns
module testbench;
  import test_support_pkg::*;
  logic ref_clk_in = 1'b0, rst_in = 1'b1, crc_calc_command_in, framing_mode_in, transmit_command_in, transmit_stop_in;
  logic rx_serial_data_in, bit_collision_in, rx_valid_strobe_in, rx_stop_detected_in, receiver_held_reset_in;
  logic osc_clock_stable_in, osc_clock_raw_in, subcarrier_detected_in, baud_106_in, bit_tick_in;
  logic tx_start_bit_in, tx_data_bit_in, tx_parity_bit_in, tx_crc_bit_in;
  logic rx_start_bit_in, rx_data_bit_in, rx_parity_bit_in, rx_crc_bit_in, lvl1, lvl2, bb;
  logic fifo_flush_out, fifo_write_out, crc_start_out, selftest_busy_out, selftest_done_out, prbs_bit_out;
  logic aux_pin_first_out, aux_pin_first_oe_out, aux_first_dac_en_out, prbs_active_out;
  logic aux_pin_second_out, aux_pin_second_oe_out, aux_second_dac_en_out;
  logic [7:0]  auto_test_control_in, aux_output_select_in, fifo_write_data_out;
  logic [5:0]  dac_value_first_in, dac_value_second_in, correlation_level_in, minimum_rx_level_in;
  logic [5:0]  adc_in_phase_in, adc_quadrature_in, data_pins_out, aux_first_dac_out, aux_second_dac_out, ep, pm;
  logic [4:0]  test_bus_group_select_in;
  logic [2:0]  test_bus_bit_select_in;
  logic [1:0]  prbs_mode_in;
  logic [31:0] seed = 32'h5, r;
  logic [47:0] e;
  logic [7:0]  sq [$];
  logic [47:0] pq [$];
  logic [23:0] got;
  logic [14:0] lf;
  logic        tk, pa, xb, par, fb;
  int          fail_count = 0, total_checks = 0, n, k, j;
  // Sync pattern the design uses by default
  localparam logic [7:0] SYNC_EXP = 8'hA5;

  test_signal_mux_and_selftest test_signal_mux_and_selftest_i (.*);
  scope_probe scope_probe_i (.osc_clock_raw_out(osc_clock_raw_in), .first_in(aux_pin_first_out),
    .first_oe_in(aux_pin_first_oe_out), .second_in(aux_pin_second_out), .second_oe_in(aux_pin_second_oe_out),
    .first_level_out(lvl1), .second_level_out(lvl2));

  always #5 ref_clk_in = ~ref_clk_in;

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Returns {mask, value} over {oe, level, dac enable, dac}
  function automatic logic [17:0] aux_exp(input logic [3:0] c, input logic [5:0] own);
    logic t, x;
    t = baud_106_in ? (tx_start_bit_in | tx_data_bit_in | tx_parity_bit_in | tx_crc_bit_in)
                    : (tx_data_bit_in | tx_crc_bit_in);
    x = baud_106_in ? (rx_data_bit_in | rx_parity_bit_in | rx_crc_bit_in) : (rx_data_bit_in | rx_crc_bit_in);
    case (c)
      4'h1: return {9'h1FF, 3'b001, own};
      4'h2: return {9'h1FF, 3'b001, correlation_level_in};
      4'h4: return {9'h1FF, 3'b001, minimum_rx_level_in};
      4'h5: return {9'h1FF, 3'b001, adc_in_phase_in};
      4'h6: return {9'h1FF, 3'b001, adc_quadrature_in};
      4'hA: return {9'h1C0, 9'h180};
      4'hB: return {9'h1C0, 9'h100};
      4'hC: return {9'h1C0, 1'b1, t, 7'h00};
      4'hD: return {9'h1C0, 1'b1, x, 7'h00};
      4'hE: return {9'h1C0, 1'b1, subcarrier_detected_in, 7'h00};
      4'hF: return {9'h1C0, 1'b1, bb, 7'h00};
      default: return {9'h1C0, 9'h000};
    endcase
  endfunction

  task automatic check(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task close_out();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One strobe per request, back to idle between requests
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge ref_clk_in);
    #1 s = 1'b0;
  endtask

  initial forever begin
    r = rnd();
    {rx_serial_data_in, bit_collision_in, rx_valid_strobe_in, rx_stop_detected_in, receiver_held_reset_in,
     osc_clock_stable_in, subcarrier_detected_in, baud_106_in, tx_start_bit_in, tx_data_bit_in, tx_parity_bit_in,
     tx_crc_bit_in, rx_start_bit_in, rx_data_bit_in, rx_parity_bit_in, rx_crc_bit_in, bit_tick_in} = r[16:0];
    r = rnd();
    {correlation_level_in, minimum_rx_level_in, adc_in_phase_in, adc_quadrature_in, dac_value_first_in} = r[29:0];
    r = rnd();
    {aux_output_select_in, dac_value_second_in} = r[13:0];
    test_bus_group_select_in = r[14] ? TB_GROUP_RX : (r[15] ? TB_GROUP_OSC : r[20:16]);
    test_bus_bit_select_in = {r[21], 2'b10};
    @(posedge ref_clk_in);
    #1;
  end

  // Outputs at each edge answer the inputs noted one edge earlier
  always @(posedge ref_clk_in) begin
    #4;
    if (fifo_write_out) check(fifo_write_data_out, sq.size() ? sq.pop_front() : 8'hFF);
    if (pq.size()) begin
      e = pq.pop_front();
      got = {data_pins_out, aux_pin_first_oe_out, lvl1, aux_first_dac_en_out, aux_first_dac_out, aux_pin_second_oe_out,
             lvl2, aux_second_dac_en_out, aux_second_dac_out};
      check(got[23:18] & e[47:42], e[23:18]);
      check(got[17:9] & e[41:33], e[17:9]);
      check(got[8:0] & e[32:24], e[8:0]);
    end
    ep = 6'h00;
    pm = 6'h3F;
    if (test_bus_group_select_in == TB_GROUP_RX)
      ep = {rx_serial_data_in, bit_collision_in & baud_106_in, rx_valid_strobe_in, rx_stop_detected_in,
            receiver_held_reset_in, 1'b0};
    if (test_bus_group_select_in == TB_GROUP_OSC) {ep, pm} = {osc_clock_stable_in, 3'b000, osc_clock_raw_in, 7'h2F};
    bb = test_bus_bit_select_in[2] ? ep[5] : ep[1];
    e = {12'h000, aux_exp(aux_output_select_in[7:4], dac_value_first_in),
         aux_exp(aux_output_select_in[3:0], dac_value_second_in)};
    if (!rst_in) pq.push_back({pm, e[35:27], e[17:9], ep, e[26:18], e[8:0]});
    // Sequence model: one bit per tick taken while the lane stays active
    if (tk && pa && prbs_active_out) begin
      j = framing_mode_in ? k - 16 : k;
      if (j < 0) xb = (k < 8) ? 1'b0 : SYNC_EXP[k - 8];
      else if (j == 0) {xb, par} = 2'b11;
      else if ((j - 1) % 9 == 8) {xb, par} = {par, 1'b1};
      else begin
        fb = (prbs_mode_in == PRBS_15) ? lf[14] ^ lf[13] : lf[8] ^ lf[4];
        {xb, par, lf} = {fb, par ^ fb, lf[13:0], fb};
      end
      check(prbs_bit_out, xb);
      k++;
    end
    if (!prbs_active_out) begin
      k = 0;
      lf = PRBS_SEED;
    end
    {tk, pa} = {bit_tick_in, prbs_active_out};
  end

  initial begin
    {auto_test_control_in, crc_calc_command_in, prbs_mode_in, framing_mode_in, transmit_command_in} = '0;
    transmit_stop_in = 1'b0;
    repeat (20) @(posedge ref_clk_in);
    // Reset release stands in for the host's soft reset
    #1 rst_in = 1'b0;
    repeat (40) @(posedge ref_clk_in);
    #1 auto_test_control_in = SELFTEST_ARM_CODE;
    for (int i = 0; i < SIG_BYTES; i++) sq.push_back(SIG_ROM[i]);
    @(posedge ref_clk_in);  // Slot of the host's single zero byte into the FIFO
    #1 pulse(crc_calc_command_in);
    #2 check({fifo_flush_out, selftest_busy_out, crc_start_out}, 3'b110);
    // A second launch while busy must be ignored
    repeat (10) @(posedge ref_clk_in);
    #1 pulse(crc_calc_command_in);
    n = 0;
    while (selftest_done_out !== 1'b1 && n < 100) begin
      @(posedge ref_clk_in);
      #4 n++;
    end
    check({n < 100, 31'(sq.size())}, 32'h80000000);
    @(posedge ref_clk_in);
    #1 auto_test_control_in = 8'h00;
    pulse(crc_calc_command_in);
    #2 check({crc_start_out, selftest_busy_out, fifo_flush_out}, 3'b100);
    for (int m = 1; m < 3; m++) begin
      @(posedge ref_clk_in);
      #1 {prbs_mode_in, framing_mode_in} = {m[1:0], m[1]};
      @(posedge ref_clk_in);
      #1 pulse(transmit_command_in);
      @(posedge ref_clk_in);
      #3 check(prbs_active_out, 1);
      repeat (80) @(posedge ref_clk_in);
      #1 pulse(transmit_stop_in);
      repeat (2) @(posedge ref_clk_in);
      #3 check(prbs_active_out, 0);
    end
    @(posedge ref_clk_in);
    #1 prbs_mode_in = PRBS_OFF;
    repeat (3000) @(posedge ref_clk_in);
    close_out();
  end

  initial begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule
